/* logic/xap_core.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1 - port-direction load with select 6 copies the accumulator there and keeps all flags; code keeps only zero, carries follow their inputs.
// RULE2 - the literal XOR writes accumulator XOR an 8-bit immediate back into the accumulator.
// RULE3 - the literal XOR changes only the zero flag, never carry or digit carry.
// RULE4 - the file XOR combines the accumulator with the file register picked by a 5-bit address.
// RULE5 - file XOR with destination bit 0 writes the accumulator, with 1 the file register.
// RULE6 - the file XOR changes only the zero flag, whichever destination is used.
// RULE7 - when an XOR updates the zero flag it is set for a zero result and cleared otherwise.
module xap_core
  import xap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire xap_op_e op,
  input wire logic [XAP_DATA_W-1:0] literal,
  input wire logic [XAP_FADDR_W-1:0] file_addr,
  input wire logic dest,
  input wire logic [2:0] port_sel,
  input wire logic [XAP_DATA_W-1:0] file_rdata,
  input wire logic carry_in,
  input wire logic digit_carry_in,
  output logic [XAP_DATA_W-1:0] accum,
  output logic [XAP_DATA_W-1:0] port_dir,
  output logic zero_flag,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic file_we,
  output logic [XAP_FADDR_W-1:0] file_waddr,
  output logic [XAP_DATA_W-1:0] file_wdata
);

  // ****************************************
  // next state
  // ****************************************
  logic [XAP_DATA_W-1:0] accum_q, accum_d, dir_q, dir_d, wdata_q, wdata_d;
  logic zero_q, zero_d, carry_q, carry_d, dc_q, dc_d, we_q, we_d;
  logic [XAP_FADDR_W-1:0] waddr_q, waddr_d;
  // one shared result so a single zero detector serves both xor ops
  logic [XAP_DATA_W-1:0] result;

  always_comb begin
    accum_d = accum_q;
    dir_d = dir_q;
    zero_d = zero_q;
    // carry bits are owned elsewhere; the xor ops pass them through untouched
    carry_d = carry_in; // RULE3
    dc_d = digit_carry_in; // RULE6
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    result = XAP_ZERO;
    case (op)
      XAP_OP_DIR_LOAD: begin
        // other selects have no direction register here, so they fall through
        if (port_sel == XAP_PORT_SEL) begin
          dir_d = accum_q; // RULE1
        end
      end
      XAP_OP_XOR_LIT: begin
        result = accum_q ^ literal; // RULE2
        accum_d = result;
        zero_d = (result == XAP_ZERO); // RULE3 RULE7
      end
      XAP_OP_XOR_FILE: begin
        result = accum_q ^ file_rdata; // RULE4
        zero_d = (result == XAP_ZERO); // RULE6 RULE7
        if (dest == XAP_DEST_F) begin
          // accumulator keeps its value so a following op chains off it
          we_d = 1'b1; // RULE5
          waddr_d = file_addr;
          wdata_d = result;
        end else begin
          accum_d = result; // RULE5
        end
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    // reset leaves every port pin an input until software loads it
    if (rst) begin
      accum_q <= XAP_W_RST;
      dir_q <= XAP_DIR_RST;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
      dc_q <= 1'b0;
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= XAP_ZERO;
    end else begin
      accum_q <= accum_d;
      dir_q <= dir_d;
      zero_q <= zero_d;
      carry_q <= carry_d;
      dc_q <= dc_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a flop, so nothing ripples combinationally out of the core
  assign accum = accum_q;
  assign port_dir = dir_q;
  assign zero_flag = zero_q;
  assign carry_flag = carry_q;
  assign digit_carry_flag = dc_q;
  assign file_we = we_q;
  assign file_waddr = waddr_q;
  assign file_wdata = wdata_q;

  // ****************************************
  // checks
  // ****************************************
  property p_dir_load;
    @(posedge core_clk) disable iff (rst)
    (op == XAP_OP_DIR_LOAD && port_sel == XAP_PORT_SEL)
      |=> (port_dir == $past(accum) && zero_flag == $past(zero_flag)
           && accum == $past(accum));
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong"); // RULE1

  property p_xor_lit;
    @(posedge core_clk) disable iff (rst)
    op == XAP_OP_XOR_LIT |=> accum == ($past(accum) ^ $past(literal));
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong"); // RULE2

  property p_lit_carry;
    @(posedge core_clk) disable iff (rst)
    op == XAP_OP_XOR_LIT |=> (carry_flag == $past(carry_in)
                              && digit_carry_flag == $past(digit_carry_in));
  endproperty
  a_lit_carry: assert property (p_lit_carry) else $error("literal xor hit carry"); // RULE3

  property p_file_w;
    @(posedge core_clk) disable iff (rst)
    (op == XAP_OP_XOR_FILE && dest == XAP_DEST_W)
      |=> (accum == ($past(accum) ^ $past(file_rdata)) && !file_we);
  endproperty
  a_file_w: assert property (p_file_w) else $error("file xor to accumulator wrong"); // RULE4

  property p_file_f;
    @(posedge core_clk) disable iff (rst)
    (op == XAP_OP_XOR_FILE && dest == XAP_DEST_F)
      |=> (file_we && file_waddr == $past(file_addr)
           && file_wdata == ($past(accum) ^ $past(file_rdata)) && $stable(accum));
  endproperty
  a_file_f: assert property (p_file_f) else $error("file xor writeback wrong"); // RULE5

  property p_file_carry;
    @(posedge core_clk) disable iff (rst)
    op == XAP_OP_XOR_FILE |=> (carry_flag == $past(carry_in)
                               && digit_carry_flag == $past(digit_carry_in));
  endproperty
  a_file_carry: assert property (p_file_carry) else $error("file xor hit carry"); // RULE6

  property p_zero;
    @(posedge core_clk) disable iff (rst)
    (op == XAP_OP_XOR_LIT)
      |=> zero_flag == (($past(accum) ^ $past(literal)) == XAP_ZERO);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE7

  property p_zero_file;
    @(posedge core_clk) disable iff (rst)
    (op == XAP_OP_XOR_FILE)
      |=> zero_flag == (($past(accum) ^ $past(file_rdata)) == XAP_ZERO);
  endproperty
  a_zero_file: assert property (p_zero_file) else $error("file zero flag wrong"); // RULE7

  // ****************************************
  // checks on refused ops, idle ops and stray writes
  // ****************************************
  // these holds catch a next-state default that leaks a stray update
  property p_dir_refused;
    @(posedge core_clk) disable iff (rst)
    (op == XAP_OP_DIR_LOAD && port_sel != XAP_PORT_SEL)
      |=> ($stable(port_dir) && $stable(accum) && $stable(zero_flag)
           && !file_we);
  endproperty
  a_dir_refused: assert property (p_dir_refused) else $error("bad refused load"); // RULE1

  property p_dir_hold;
    @(posedge core_clk) disable iff (rst)
    !(op == XAP_OP_DIR_LOAD && port_sel == XAP_PORT_SEL)
      |=> $stable(port_dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction reg moved"); // RULE1

  property p_zero_keep;
    @(posedge core_clk) disable iff (rst)
    (op != XAP_OP_XOR_LIT && op != XAP_OP_XOR_FILE)
      |=> ($stable(zero_flag) && $stable(accum));
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("idle op changed state"); // RULE1

  property p_lit_no_write;
    @(posedge core_clk) disable iff (rst)
    op == XAP_OP_XOR_LIT |=> (!file_we && $stable(port_dir));
  endproperty
  a_lit_no_write: assert property (p_lit_no_write) else $error("literal xor wrote"); // RULE2

  property p_no_write;
    @(posedge core_clk) disable iff (rst)
    !(op == XAP_OP_XOR_FILE && dest == XAP_DEST_F) |=> !file_we;
  endproperty
  a_no_write: assert property (p_no_write) else $error("stray file write"); // RULE5

  property p_wr_hold;
    @(posedge core_clk) disable iff (rst)
    !(op == XAP_OP_XOR_FILE && dest == XAP_DEST_F)
      |=> ($stable(file_waddr) && $stable(file_wdata));
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write port moved"); // RULE5

endmodule : xap_core

/* logic/xap_pkg.sv */
package xap_pkg;
  localparam int unsigned XAP_DATA_W = 8;
  localparam int unsigned XAP_FADDR_W = 5;
  localparam logic [2:0] XAP_PORT_SEL = 3'h6;
  localparam logic [7:0] XAP_W_RST = 8'h00;
  localparam logic [7:0] XAP_DIR_RST = 8'hFF;
  localparam logic [7:0] XAP_ZERO = 8'h00;
  localparam logic XAP_DEST_W = 1'b0;
  localparam logic XAP_DEST_F = 1'b1;
  typedef enum logic [1:0] {
    XAP_OP_NONE,
    XAP_OP_DIR_LOAD,
    XAP_OP_XOR_LIT,
    XAP_OP_XOR_FILE
  } xap_op_e;
endpackage : xap_pkg

/* tb/xor_and_port_direction_ops_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t got %0h exp %0h", $time, a, e); end end
module xor_and_port_direction_ops_tb_top;
  import xap_pkg::*;
  logic core_clk, rst, dest, carry_in, digit_carry_in, file_we;
  logic zero_flag, carry_flag, digit_carry_flag, z_m, we_m;
  xap_op_e op;
  logic [7:0] literal, file_rdata, accum, port_dir, file_wdata, w_m, dir_m, r;
  logic [4:0] file_addr, file_waddr;
  logic [2:0] port_sel;
  int error_cnt, n_compared, i;
  xap_core DUT (.core_clk(core_clk), .rst(rst), .op(op), .literal(literal),
    .file_addr(file_addr), .dest(dest), .port_sel(port_sel), .file_rdata(file_rdata),
    .carry_in(carry_in), .digit_carry_in(digit_carry_in), .accum(accum),
    .port_dir(port_dir), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ************
  // checks
  // ************
  function automatic logic [7:0] xor_res(input logic [7:0] w, input logic [7:0] v);
    return w ^ v;
  endfunction : xor_res
  task automatic step(input xap_op_e o, input logic [7:0] k, f, input logic [4:0] a,
    input logic d, input logic [2:0] p);
    op = o;
    literal = k;
    file_rdata = f;
    file_addr = a;
    dest = d;
    port_sel = p;
    carry_in = 1'($urandom);
    digit_carry_in = 1'($urandom);
    r = xor_res(w_m, (o == XAP_OP_XOR_LIT) ? k : f);
    we_m = 1'b0;
    if (o == XAP_OP_DIR_LOAD && p == XAP_PORT_SEL) dir_m = w_m;
    if (o == XAP_OP_XOR_LIT || o == XAP_OP_XOR_FILE) begin
      z_m = (r == XAP_ZERO);
      if (o == XAP_OP_XOR_FILE && d == XAP_DEST_F) we_m = 1'b1;
      else w_m = r;
    end
    @(negedge core_clk);
    `CHK(accum, w_m)
    `CHK(port_dir, dir_m)
    `CHK(zero_flag, z_m)
    `CHK(carry_flag, carry_in)
    `CHK(digit_carry_flag, digit_carry_in)
    `CHK(file_we, we_m)
    if (we_m) begin
      `CHK(file_waddr, a)
      `CHK(file_wdata, r)
    end
  endtask : step
  task automatic stop_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // watchdog sized well past the few hundred ops below
  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    op = XAP_OP_NONE;
    literal = 8'h00;
    file_rdata = 8'h00;
    file_addr = 5'h00;
    dest = 1'b0;
    port_sel = 3'h0;
    carry_in = 1'b0;
    digit_carry_in = 1'b0;
    w_m = XAP_W_RST;
    dir_m = XAP_DIR_RST;
    z_m = 1'b0;
    void'($urandom(32'h202c166b));
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    `CHK(port_dir, XAP_DIR_RST)
    `CHK(accum, w_m)
    `CHK(zero_flag, z_m)
    `CHK(carry_flag, 1'b0)
    `CHK(file_we, 1'b0)
    step(XAP_OP_XOR_LIT, 8'hA5, 8'h00, 5'h00, 1'b0, 3'h0);
    step(XAP_OP_DIR_LOAD, 8'h00, 8'h00, 5'h00, 1'b0, 3'h7);
    step(XAP_OP_DIR_LOAD, 8'h00, 8'h00, 5'h00, 1'b0, 3'h6);
    step(XAP_OP_XOR_FILE, 8'h00, 8'hA5, 5'h1F, 1'b1, 3'h0);
    step(XAP_OP_XOR_FILE, 8'h00, 8'hA5, 5'h1F, 1'b0, 3'h0);
    step(XAP_OP_XOR_LIT, 8'hFF, 8'h00, 5'h00, 1'b0, 3'h0);
    step(XAP_OP_NONE, 8'hFF, 8'h12, 5'h03, 1'b1, 3'h6);
    for (i = 0; i < 300; i++) begin
      step(xap_op_e'(2'($urandom)), 8'($urandom), 8'($urandom), 5'($urandom),
        1'($urandom), 3'($urandom));
    end
    stop_test();
  end
endmodule : xor_and_port_direction_ops_tb_top
